// [hdl/dfae_consts.vh]
`ifndef DFAE_CONSTS_VH
`define DFAE_CONSTS_VH

// Register byte offsets
`define DFAE_REG_FILE_SEL   8'h00
`define DFAE_REG_OP_SEL     8'h04
`define DFAE_REG_TRIGGER    8'h08
`define DFAE_REG_OPEN_KIND  8'h0C
`define DFAE_REG_POSITION   8'h10
`define DFAE_REG_XFER_COUNT 8'h14
`define DFAE_REG_OUTCOME    8'h18
`define DFAE_REG_MOVED      8'h1C
`define DFAE_REG_TOTAL      8'h20
`define DFAE_REG_BUSY       8'h24
`define DFAE_REG_IRQ_STAT   8'h28
`define DFAE_REG_IRQ_MASK   8'h2C
`define DFAE_WIN_BASE_HI    2'h1

// Target file choice
`define DFAE_FILE_DEFAULT   3'h0
`define DFAE_FILE_SET_ONE   3'h1
`define DFAE_FILE_SET_TWO   3'h2
`define DFAE_FILE_SET_THREE 3'h3
`define DFAE_FILE_LUMA      3'h4
`define DFAE_FILE_RED       3'h5
`define DFAE_FILE_GREEN     3'h6
`define DFAE_FILE_BLUE      3'h7
`define DFAE_NUM_FILES      8

// Operation choice
`define DFAE_OP_OPEN        3'h0
`define DFAE_OP_CLOSE       3'h1
`define DFAE_OP_READ        3'h2
`define DFAE_OP_WRITE       3'h3
`define DFAE_OP_DELETE      3'h4

// Open access kind
`define DFAE_KIND_READ      2'h0
`define DFAE_KIND_WRITE     2'h1
`define DFAE_KIND_RW        2'h2

// Operation outcome
`define DFAE_OUT_SUCCESS    4'h0
`define DFAE_OUT_FAILURE    4'h1
`define DFAE_OUT_NOT_OPEN   4'h2
`define DFAE_OUT_DENIED     4'h3
`define DFAE_OUT_PARTIAL    4'h4

// Sizes
`define DFAE_FILE_BYTES     8'h40
`define DFAE_WIN_BYTES      8'h10

// Interrupt status bits
`define DFAE_IRQ_DONE_BIT   0
`define DFAE_IRQ_FAIL_BIT   1

// Reset values
`define DFAE_RST_FILE_SEL   3'h0
`define DFAE_RST_OP_SEL     3'h0
`define DFAE_RST_KIND       2'h2

`endif

// [hdl/dfae_engine.v]
`timescale 1ns/10ps
`include "dfae_consts.vh"

// Overview of operation
// - The target file choice covers the default file, three settings files and four tables.
// - Open, close, read, write and delete are chosen and only run on the operation trigger.
// - Open marks the chosen file open in the current open access kind.
// - Close marks the chosen file closed.
// - Read copies the byte count from storage at the file position into the window.
// - Write copies the byte count from the window into storage at the file position.
// - Delete empties the chosen file while its entry stays usable.
// - The open access kind encodes read-only, write-only and read-and-write.
// - Data moves between window and storage only while a triggered transfer runs.
// - The file position is per file and operation and only reachable for read or write.
// - The transfer byte count is per file and operation and only reachable for read or write.
// - A read-only outcome reports success or a failure code after each operation.
// - The generic failure value is used when no finer code applies.
// - Each trigger write with bit 0 set while idle runs the chosen operation on the chosen file; one while busy is ignored.
// - A read-only count reports the bytes actually moved by a read or write.
// - A read-only total reports the current stored length of the chosen file.
module dfae_engine
(
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Interrupt
    output reg         irq
);

    localparam S_IDLE = 2'h0;
    localparam S_XFER = 2'h1;
    localparam S_DONE = 2'h2;

    reg  [2:0]  file_sel_reg;
    reg  [2:0]  op_sel_reg;
    reg  [1:0]  irq_stat_reg;
    reg  [1:0]  irq_mask_reg;
    reg  [1:0]  state_reg;
    reg  [7:0]  cnt_reg;
    reg  [7:0]  n_reg;
    reg  [7:0]  pos_reg;
    reg  [7:0]  want_reg;
    reg  [2:0]  xfile_reg;
    reg         xwrite_reg;
    reg  [3:0]  outcome_reg;
    reg  [7:0]  moved_reg;
    reg  [3:0]  pend_out_reg;
    reg  [1:0]  kind_reg [0:`DFAE_NUM_FILES-1];
    reg  [7:0]  pos_mem [0:15];
    reg  [7:0]  len_mem [0:15];
    reg  [7:0]  store [0:511];
    reg  [7:0]  window [0:15];
    wire [7:0]  size_w [0:`DFAE_NUM_FILES-1];
    wire [`DFAE_NUM_FILES-1:0] open_w;
    wire [1:0]  mode_w [0:`DFAE_NUM_FILES-1];

    // Engine strobes to per-file state
    reg         set_open;
    reg         set_close;
    reg         set_delete;
    reg         set_size;
    reg  [7:0]  new_size;

    wire        is_xop   = (op_sel_reg == `DFAE_OP_READ) || (op_sel_reg == `DFAE_OP_WRITE);
    wire [3:0]  sel_idx  = {file_sel_reg, op_sel_reg == `DFAE_OP_WRITE};
    wire [7:0]  cur_pos  = pos_mem[sel_idx];
    wire [7:0]  cur_len  = len_mem[sel_idx];
    wire [7:0]  cur_size = size_w[file_sel_reg];
    wire [1:0]  cur_kind = kind_reg[file_sel_reg];
    wire        win_hit  = (reg_addr[7:6] == `DFAE_WIN_BASE_HI);
    wire [8:0]  st_addr  = {xfile_reg, pos_reg[5:0] + cnt_reg[5:0]};
    wire [7:0]  end_pos  = pos_reg + n_reg;
    wire        trigger  = reg_wr && (reg_addr == `DFAE_REG_TRIGGER) && reg_wdata[0];

    // Byte limit for the chosen transfer
    reg  [7:0]  lim;
    reg  [7:0]  xn;
    always @*
    begin
        lim = 8'h00;
        if (op_sel_reg == `DFAE_OP_READ)
        begin
            if (cur_size > cur_pos)
                lim = cur_size - cur_pos;
        end
        else if (`DFAE_FILE_BYTES > cur_pos)
            lim = `DFAE_FILE_BYTES - cur_pos;
        if (lim > `DFAE_WIN_BYTES)
            lim = `DFAE_WIN_BYTES;
        xn = (cur_len < lim) ? cur_len : lim;
    end

    // Software-written settings
    integer i;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            file_sel_reg <= `DFAE_RST_FILE_SEL;
            op_sel_reg   <= `DFAE_RST_OP_SEL;
            irq_mask_reg <= 2'h0;
            for (i = 0; i < `DFAE_NUM_FILES; i = i + 1)
                kind_reg[i] <= `DFAE_RST_KIND;
            for (i = 0; i < 16; i = i + 1)
            begin
                pos_mem[i] <= 8'h00;
                len_mem[i] <= 8'h00;
            end
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `DFAE_REG_FILE_SEL:
                    file_sel_reg <= reg_wdata[2:0];
                `DFAE_REG_OP_SEL:
                    if (reg_wdata[2:0] <= `DFAE_OP_DELETE)
                        op_sel_reg <= reg_wdata[2:0];
                `DFAE_REG_OPEN_KIND:
                    if (reg_wdata[1:0] != 2'h3)
                        kind_reg[file_sel_reg] <= reg_wdata[1:0];
                `DFAE_REG_POSITION:
                    if (is_xop)
                        pos_mem[sel_idx] <= reg_wdata[7:0];
                `DFAE_REG_XFER_COUNT:
                    if (is_xop)
                        len_mem[sel_idx] <= reg_wdata[7:0];
                `DFAE_REG_IRQ_MASK:
                    irq_mask_reg <= reg_wdata[1:0];
                default:
                    ;
            endcase
        end
    end

    // Operation sequencer
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg    <= S_IDLE;
            cnt_reg      <= 8'h00;
            n_reg        <= 8'h00;
            pos_reg      <= 8'h00;
            want_reg     <= 8'h00;
            xfile_reg    <= 3'h0;
            xwrite_reg   <= 1'b0;
            outcome_reg  <= `DFAE_OUT_SUCCESS;
            moved_reg    <= 8'h00;
            pend_out_reg <= `DFAE_OUT_SUCCESS;
            set_open     <= 1'b0;
            set_close    <= 1'b0;
            set_delete   <= 1'b0;
            set_size     <= 1'b0;
            new_size     <= 8'h00;
        end
        else
        begin
            set_open   <= 1'b0;
            set_close  <= 1'b0;
            set_delete <= 1'b0;
            set_size   <= 1'b0;
            case (state_reg)
                S_IDLE:
                    if (trigger)
                    begin
                        xfile_reg    <= file_sel_reg;
                        xwrite_reg   <= (op_sel_reg == `DFAE_OP_WRITE);
                        pos_reg      <= cur_pos;
                        want_reg     <= is_xop ? cur_len : 8'h00;
                        cnt_reg      <= 8'h00;
                        n_reg        <= 8'h00;
                        pend_out_reg <= `DFAE_OUT_SUCCESS;
                        state_reg    <= S_DONE;
                        case (op_sel_reg)
                            `DFAE_OP_OPEN:
                                set_open <= 1'b1;
                            `DFAE_OP_CLOSE:
                                if (open_w[file_sel_reg])
                                    set_close <= 1'b1;
                                else
                                    pend_out_reg <= `DFAE_OUT_FAILURE;
                            `DFAE_OP_DELETE:
                                set_delete <= 1'b1;
                            `DFAE_OP_READ, `DFAE_OP_WRITE:
                                if (!open_w[file_sel_reg])
                                    pend_out_reg <= `DFAE_OUT_NOT_OPEN;
                                else if ((op_sel_reg == `DFAE_OP_READ &&
                                          mode_w[file_sel_reg] == `DFAE_KIND_WRITE) ||
                                         (op_sel_reg == `DFAE_OP_WRITE &&
                                          mode_w[file_sel_reg] == `DFAE_KIND_READ))
                                    pend_out_reg <= `DFAE_OUT_DENIED;
                                else
                                begin
                                    n_reg     <= xn;
                                    state_reg <= S_XFER;
                                end
                            default:
                                pend_out_reg <= `DFAE_OUT_FAILURE;
                        endcase
                    end
                S_XFER:
                    if (cnt_reg == n_reg)
                        state_reg <= S_DONE;
                    else
                        cnt_reg <= cnt_reg + 8'h01;
                S_DONE:
                begin
                    if (pend_out_reg == `DFAE_OUT_SUCCESS && cnt_reg < want_reg)
                        outcome_reg <= `DFAE_OUT_PARTIAL;
                    else
                        outcome_reg <= pend_out_reg;
                    moved_reg <= cnt_reg;
                    if (xwrite_reg && cnt_reg != 8'h00 && end_pos > size_w[xfile_reg])
                    begin
                        set_size <= 1'b1;
                        new_size <= end_pos;
                    end
                    state_reg <= S_IDLE;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    // Per-file open flag and stored length
    genvar g;
    generate
        for (g = 0; g < `DFAE_NUM_FILES; g = g + 1)
        begin : file_state
            reg        open_reg;
            reg [7:0]  size_reg;
            reg [1:0]  mode_reg;
            assign open_w[g] = open_reg;
            assign mode_w[g] = mode_reg;
            assign size_w[g] = size_reg;
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    open_reg <= 1'b0;
                    size_reg <= 8'h00;
                    mode_reg <= `DFAE_RST_KIND;
                end
                else if (xfile_reg == g)
                begin
                    if (set_open)
                    begin
                        open_reg <= 1'b1;
                        mode_reg <= kind_reg[g];
                    end
                    else if (set_close || set_delete)
                        open_reg <= 1'b0;
                    if (set_delete)
                        size_reg <= 8'h00;
                    else if (set_size)
                        size_reg <= new_size;
                end
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (state_reg == S_XFER && xwrite_reg && cnt_reg != n_reg)
            store[st_addr] <= window[cnt_reg[3:0]];
    end

    // storage to window; bus writes blocked while busy
    always @(posedge clk)
    begin
        if (state_reg == S_XFER && !xwrite_reg && cnt_reg != n_reg)
            window[cnt_reg[3:0]] <= store[st_addr];
        else if (state_reg == S_IDLE && reg_wr && win_hit)
            window[reg_addr[5:2]] <= reg_wdata[7:0];
    end

    // Sticky events; a new event beats a same-cycle clear
    wire       op_done = (state_reg == S_DONE);
    wire       op_fail = op_done &&
                         (pend_out_reg != `DFAE_OUT_SUCCESS || cnt_reg < want_reg);
    wire [1:0] ev      = {op_fail, op_done};
    wire [1:0] clr     = (reg_wr && reg_addr == `DFAE_REG_IRQ_STAT) ? reg_wdata[1:0] : 2'h0;
    wire [1:0] stat_next = (irq_stat_reg & ~clr) | ev;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_stat_reg <= 2'h0;
            irq          <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= stat_next;
            irq          <= |(stat_next & irq_mask_reg);
        end
    end

    // Read data, valid in the cycle after the strobe only
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h00000000;
        else if (!reg_rd)
            reg_rdata <= 32'h00000000;
        else if (win_hit)
            reg_rdata <= {24'h000000, window[reg_addr[5:2]]};
        else
        begin
            case (reg_addr)
                `DFAE_REG_FILE_SEL:
                    reg_rdata <= {29'h0, file_sel_reg};
                `DFAE_REG_OP_SEL:
                    reg_rdata <= {29'h0, op_sel_reg};
                `DFAE_REG_OPEN_KIND:
                    reg_rdata <= {30'h0, cur_kind};
                `DFAE_REG_POSITION:
                    reg_rdata <= is_xop ? {24'h0, cur_pos} : 32'h00000000;
                `DFAE_REG_XFER_COUNT:
                    reg_rdata <= is_xop ? {24'h0, cur_len} : 32'h00000000;
                `DFAE_REG_OUTCOME:
                    reg_rdata <= {28'h0, outcome_reg};
                `DFAE_REG_MOVED:
                    reg_rdata <= {24'h0, moved_reg};
                `DFAE_REG_TOTAL:
                    reg_rdata <= {24'h0, cur_size};
                `DFAE_REG_BUSY:
                    reg_rdata <= {31'h0, state_reg != S_IDLE};
                `DFAE_REG_IRQ_STAT:
                    reg_rdata <= {30'h0, irq_stat_reg};
                `DFAE_REG_IRQ_MASK:
                    reg_rdata <= {30'h0, irq_mask_reg};
                default:
                    reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// [verif/dfae_engine_properties.sv]
`timescale 1ns/10ps
`include "dfae_consts.vh"
module dfae_chk
(
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Interrupt
    input wire        irq
);
    reg  [7:0] since_reg;
    reg        rw_op_reg;
    reg        known_reg;
    wire       mask_wr = reg_wr && reg_addr == `DFAE_REG_IRQ_MASK;
    wire       op_wr   = reg_wr && reg_addr == `DFAE_REG_OP_SEL && reg_wdata[2:0] <= 3'h4;
    wire       file_wr = reg_wr && reg_addr == `DFAE_REG_FILE_SEL;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Cycles since trigger; operation choice unknown after a file change
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            since_reg <= 8'hFF;
            rw_op_reg <= 1'b0;
            known_reg <= 1'b1;
        end
        else
        begin
            if (reg_wr && reg_addr == `DFAE_REG_TRIGGER && reg_wdata[0])
                since_reg <= 8'h00;
            else if (since_reg != 8'hFF)
                since_reg <= since_reg + 8'h01;
            if (op_wr)
                rw_op_reg <= reg_wdata[2:0] == `DFAE_OP_READ || reg_wdata[2:0] == `DFAE_OP_WRITE;
            known_reg <= op_wr || (known_reg && !file_wr);
        end
    end

    property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_pos_gate;
        reg_rd && reg_addr == `DFAE_REG_POSITION && known_reg && !rw_op_reg
            |=> reg_rdata == 32'h0;
    endproperty
    a_pos_gate: assert property (p_pos_gate) else $error("position visible");
    property p_cnt_gate;
        reg_rd && reg_addr == `DFAE_REG_XFER_COUNT && known_reg && !rw_op_reg
            |=> reg_rdata == 32'h0;
    endproperty
    a_cnt_gate: assert property (p_cnt_gate) else $error("count visible");
    property p_kind; reg_rd && reg_addr == `DFAE_REG_OPEN_KIND |=> reg_rdata <= 32'h2; endproperty
    a_kind: assert property (p_kind) else $error("open kind out of range");
    property p_op; reg_rd && reg_addr == `DFAE_REG_OP_SEL |=> reg_rdata <= 32'h4; endproperty
    a_op: assert property (p_op) else $error("operation out of range");
    property p_outcome; reg_rd && reg_addr == `DFAE_REG_OUTCOME |=> reg_rdata <= 32'h4; endproperty
    a_outcome: assert property (p_outcome) else $error("outcome out of range");
    property p_moved; reg_rd && reg_addr == `DFAE_REG_MOVED |=> reg_rdata <= 32'h10; endproperty
    a_moved: assert property (p_moved) else $error("moved count too large");
    property p_irq_cause;
        $rose(irq) |-> since_reg <= 8'd24 || $past(mask_wr) || $past(mask_wr, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind dfae_engine dfae_chk dfae_chk_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// [verif/dfae_host_model.sv]
`timescale 1ns/10ps
`include "dfae_consts.vh"
module dfae_host_model
(
    // Clock
    input  wire        clk,
    // Register port
    output reg  [7:0]  reg_addr  = 8'h00,
    output reg  [31:0] reg_wdata = 32'h0,
    output reg         reg_wr    = 1'b0,
    output reg         reg_rd    = 1'b0,
    input  wire [31:0] reg_rdata
);
    // Single-cycle write, data scrambled once released
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    end
    endtask

    // Data taken in the cycle after the strobe
    task rd(input [7:0] a, output [31:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    end
    endtask

    task go;
    begin
        wr(`DFAE_REG_TRIGGER, 32'h1);
    end
    endtask

    task fill(input [7:0] base);
        integer i;
    begin
        for (i = 0; i < 16; i = i + 1)
            wr(8'h40 + 8'(4 * i), {24'h0, base + 8'(i)});
    end
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
`include "dfae_consts.vh"
module testbench;
    reg         clk       = 1'b0;
    reg         arst_n    = 1'b0;
    wire [7:0]  reg_addr;
    wire [31:0] reg_wdata;
    wire        reg_wr;
    wire        reg_rd;
    wire [31:0] reg_rdata;
    wire        irq;
    integer     error_cnt = 0;
    integer     n_checks  = 0;
    integer     cycles    = 0;
    integer     i;
    reg  [31:0] v;
    reg  [31:0] b0;

    dfae_engine dfae_engine_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    dfae_host_model dfae_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    always #20 clk = ~clk;

    task give_verdict;
    begin
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end

    task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    end
    endtask

    task w(input [7:0] a, input [31:0] d);
    begin
        dfae_host_model_i.wr(a, d);
    end
    endtask

    task rc(input [7:0] a, input [31:0] exp, input string name);
    begin
        dfae_host_model_i.rd(a, v);
        chk(name, v, exp);
    end
    endtask

    task res(input [31:0] outcome, input [31:0] moved);
    begin
        rc(`DFAE_REG_OUTCOME, outcome, "outcome");
        rc(`DFAE_REG_MOVED, moved, "moved");
    end
    endtask

    // Select, trigger, then poll busy with a bound
    task run(input [2:0] o);
        integer k;
    begin
        w(`DFAE_REG_OP_SEL, {29'h0, o});
        dfae_host_model_i.go;
        dfae_host_model_i.rd(`DFAE_REG_BUSY, b0);
        v = b0;
        for (k = 0; k < 40 && v !== 32'h0; k = k + 1)
            dfae_host_model_i.rd(`DFAE_REG_BUSY, v);
        chk("busy", v, 32'h0);
    end
    endtask

    task xfer(input [2:0] o, input [31:0] pos, input [31:0] cnt);
    begin
        w(`DFAE_REG_OP_SEL, {29'h0, o});
        w(`DFAE_REG_POSITION, pos);
        w(`DFAE_REG_XFER_COUNT, cnt);
        run(o);
    end
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rc(`DFAE_REG_OPEN_KIND, 32'h2, "kind");
        rc(`DFAE_REG_XFER_COUNT, 32'h0, "count");
        res(32'h0, 32'h0);
        rc(`DFAE_REG_TOTAL, 32'h0, "total");
        rc(8'h30, 32'h0, "unmapped");
        w(`DFAE_REG_POSITION, 32'h5);
        rc(`DFAE_REG_POSITION, 32'h0, "position");
        w(`DFAE_REG_OP_SEL, 32'h7);
        rc(`DFAE_REG_OP_SEL, 32'h0, "op");
        for (i = 0; i < 8; i = i + 1)
        begin
            w(`DFAE_REG_FILE_SEL, i);
            w(`DFAE_REG_OPEN_KIND, i % 3);
            w(`DFAE_REG_OP_SEL, i % 5);
            rc(`DFAE_REG_FILE_SEL, i, "file");
            rc(`DFAE_REG_OPEN_KIND, i % 3, "kind");
            rc(`DFAE_REG_OP_SEL, i % 5, "op");
        end
        $display("test selects done");
        w(`DFAE_REG_IRQ_MASK, 32'h3);
        w(`DFAE_REG_FILE_SEL, 32'h1);
        w(`DFAE_REG_OPEN_KIND, 32'h2);
        run(`DFAE_OP_OPEN);
        rc(`DFAE_REG_IRQ_STAT, 32'h1, "status");
        chk("irq", {31'h0, irq}, 32'h1);
        w(`DFAE_REG_IRQ_STAT, 32'h1);
        @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        dfae_host_model_i.fill(8'h10);
        xfer(`DFAE_OP_WRITE, 32'h4, 32'h3);
        chk("busy", b0, 32'h1);
        res(32'h0, 32'h3);
        rc(`DFAE_REG_POSITION, 32'h4, "position");
        rc(`DFAE_REG_TOTAL, 32'h7, "total");
        w(`DFAE_REG_OP_SEL, {29'h0, `DFAE_OP_READ});
        rc(`DFAE_REG_POSITION, 32'h0, "position");
        dfae_host_model_i.fill(8'h00);
        xfer(`DFAE_OP_READ, 32'h4, 32'h3);
        for (i = 0; i < 4; i = i + 1)
            rc(8'h40 + 8'(4 * i), i < 3 ? 32'h10 + i : 32'h3, "window");
        res(32'h0, 32'h3);
        xfer(`DFAE_OP_READ, 32'h4, 32'h5);
        res(32'h4, 32'h3);
        $display("test transfers done");
        w(`DFAE_REG_IRQ_STAT, 32'h3);
        w(`DFAE_REG_FILE_SEL, 32'h2);
        run(`DFAE_OP_READ);
        res(32'h2, 32'h0);
        run(`DFAE_OP_CLOSE);
        res(32'h1, 32'h0);
        rc(`DFAE_REG_IRQ_STAT, 32'h3, "status");
        w(`DFAE_REG_FILE_SEL, 32'h3);
        run(`DFAE_OP_OPEN);
        xfer(`DFAE_OP_WRITE, 32'h0, 32'h1);
        res(32'h3, 32'h0);
        w(`DFAE_REG_OPEN_KIND, 32'h1);
        run(`DFAE_OP_WRITE);
        res(32'h3, 32'h0);
        run(`DFAE_OP_OPEN);
        run(`DFAE_OP_READ);
        res(32'h3, 32'h0);
        w(`DFAE_REG_FILE_SEL, 32'h1);
        run(`DFAE_OP_CLOSE);
        res(32'h0, 32'h0);
        run(`DFAE_OP_READ);
        res(32'h2, 32'h0);
        run(`DFAE_OP_DELETE);
        rc(`DFAE_REG_TOTAL, 32'h0, "total");
        run(`DFAE_OP_OPEN);
        res(32'h0, 32'h0);
        $display("test failures done");
        w(`DFAE_REG_IRQ_MASK, 32'h0);
        w(`DFAE_REG_IRQ_STAT, 32'h3);
        run(`DFAE_OP_CLOSE);
        chk("irq", {31'h0, irq}, 32'h0);
        w(`DFAE_REG_IRQ_MASK, 32'h1);
        rc(`DFAE_REG_IRQ_STAT, 32'h1, "status");
        chk("irq", {31'h0, irq}, 32'h1);
        $display("test interrupt done");
        give_verdict;
    end
endmodule
